// File: src/timer_split_mode_control.sv
`timescale 1ns/1ps
module timer_split_mode_control
  import timer_split_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              t0_event_pin,
  input  wire logic              t1_event_pin,
  input  wire logic              ext_irq0_input,
  input  wire logic              ext_irq1_input,
  input  wire logic              vector_t0,
  input  wire logic              vector_t1,
  input  wire logic              vector_irq0,
  input  wire logic              vector_irq1,
  output logic                   first_timer_overflow_flag,
  output logic                   second_timer_overflow_flag,
  output logic                   ext_irq0_flag,
  output logic                   ext_irq1_flag,
  output logic                   second_timer_overflow_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic rst_meta;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  logic t0_fall;
  logic t1_fall;
  logic irq0_level;
  logic irq0_rise;
  logic irq0_fall;
  logic irq1_level;
  logic irq1_rise;
  logic irq1_fall;

  pin_sync_edge u_t0_pin (.mclk(mclk), .rst_sync_n(rst_sync_n), .pin(t0_event_pin),
    .level(), .rise(), .fall(t0_fall));
  pin_sync_edge u_t1_pin (.mclk(mclk), .rst_sync_n(rst_sync_n), .pin(t1_event_pin),
    .level(), .rise(), .fall(t1_fall));
  pin_sync_edge u_irq0_pin (.mclk(mclk), .rst_sync_n(rst_sync_n), .pin(ext_irq0_input),
    .level(irq0_level), .rise(irq0_rise), .fall(irq0_fall));
  pin_sync_edge u_irq1_pin (.mclk(mclk), .rst_sync_n(rst_sync_n), .pin(ext_irq1_input),
    .level(irq1_level), .rise(irq1_rise), .fall(irq1_fall));

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0] timer_mode_register;
  logic [7:0] clock_select;
  logic [7:0] ext_irq_config_register;
  logic       first_timer_run;
  logic       second_timer_run;
  logic       ext_irq0_type_select;
  logic       ext_irq1_type_select;

  logic wr_control;
  assign wr_control = wr_en && (addr == ADDR_CONTROL);

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      timer_mode_register     <= RESET_BYTE;
      clock_select            <= RESET_BYTE;
      ext_irq_config_register <= RESET_BYTE;
    end else if (wr_en) begin
      if (addr == ADDR_MODE)
        timer_mode_register <= wr_data;
      if (addr == ADDR_CLOCK)
        clock_select <= wr_data;
      if (addr == ADDR_IRQ_CFG)
        ext_irq_config_register <= wr_data & ((8'h01 << BIT_IRQ0_POL) | (8'h01 << BIT_IRQ1_POL));
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      first_timer_run      <= 1'b0;
      second_timer_run     <= 1'b0;
      ext_irq0_type_select <= 1'b0;
      ext_irq1_type_select <= 1'b0;
    end else if (wr_control) begin
      second_timer_run     <= wr_data[BIT_T1_RUN];
      first_timer_run      <= wr_data[BIT_T0_RUN];
      ext_irq1_type_select <= wr_data[BIT_IRQ1_TYPE];
      ext_irq0_type_select <= wr_data[BIT_IRQ0_TYPE];
    end
  end

  timer_mode_type t0_mode;
  timer_mode_type t1_mode;
  logic           split;
  logic           ct0;
  logic           ct1;
  logic           t0_gate;
  logic           t1_gate;
  logic           t0m;
  logic           t1m;

  assign t0_mode = timer_mode_type'(timer_mode_register[MODE0_LSB +: 2]);
  assign t1_mode = timer_mode_type'(timer_mode_register[MODE1_LSB +: 2]);
  assign split   = (t0_mode == MODE_SPLIT);
  assign ct0     = timer_mode_register[BIT_CT0];
  assign ct1     = timer_mode_register[BIT_CT1];
  assign t0_gate = timer_mode_register[BIT_T0_GATE];
  assign t1_gate = timer_mode_register[BIT_T1_GATE];
  assign t0m     = clock_select[BIT_T0M];
  assign t1m     = clock_select[BIT_T1M];

  ////////////////////////////////////////////////////////////////////////////
  // Prescaled clock enable
  logic [PRESC_W-1:0] presc_div;
  logic [PRESC_W-1:0] presc_count;
  logic               presc_tick;

  always_comb begin
    unique case (clock_select[SCALE_LSB +: 2])
      2'h0: presc_div = DIV_12;
      2'h1: presc_div = DIV_4;
      2'h2: presc_div = DIV_48;
      2'h3: presc_div = DIV_8;
    endcase
  end

  assign presc_tick = (presc_count >= presc_div - 6'h01);

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      presc_count <= '0;
    else if (presc_tick)
      presc_count <= '0;
    else
      presc_count <= presc_count + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt activity
  logic irq0_active;
  logic irq1_active;
  logic irq0_edge;
  logic irq1_edge;

  assign irq0_active = ext_irq_config_register[BIT_IRQ0_POL] ? irq0_level : ~irq0_level;
  assign irq1_active = ext_irq_config_register[BIT_IRQ1_POL] ? irq1_level : ~irq1_level;
  assign irq0_edge   = ext_irq_config_register[BIT_IRQ0_POL] ? irq0_rise : irq0_fall;
  assign irq1_edge   = ext_irq_config_register[BIT_IRQ1_POL] ? irq1_rise : irq1_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Count enables
  logic t0_tick;
  logic t0_high_tick;
  logic t1_tick;
  logic t1_enabled;

  // Low byte: own run, gate and source select
  assign t0_tick = first_timer_run && (!t0_gate || irq0_active) &&
                   (ct0 ? t0_fall : (t0m || presc_tick));
  // High byte in split: timer only, gated by second run
  assign t0_high_tick = split && second_timer_run && (t0m || presc_tick);
  // In split the second timer runs by its mode, never from events
  assign t1_enabled = split ? (t1_mode != MODE_SPLIT)
                            : (second_timer_run && (!t1_gate || irq1_active) && (t1_mode != MODE_SPLIT));
  assign t1_tick = t1_enabled && ((ct1 && !split) ? t1_fall : (t1m || presc_tick));

  ////////////////////////////////////////////////////////////////////////////
  // Counters
  logic [7:0]  first_timer_low_byte;
  logic [7:0]  first_timer_high_byte;
  logic [7:0]  tl1;
  logic [7:0]  th1;
  logic [7:0]  next_first_timer_low_byte;
  logic [7:0]  next_first_timer_high_byte;
  logic [7:0]  next_tl1;
  logic [7:0]  next_th1;
  logic        t0_ovf;
  logic        t0_high_ovf;
  logic        t1_ovf;
  logic [13:0] t0_sum13;
  logic [16:0] t0_sum16;
  logic [8:0]  t0_low_sum;
  logic [8:0]  t0_high_sum;
  logic [13:0] t1_sum13;
  logic [16:0] t1_sum16;
  logic [8:0]  tl1_sum;

  assign t0_sum13    = {1'b0, first_timer_high_byte, first_timer_low_byte[4:0]} + 14'h0001;
  assign t0_sum16    = {1'b0, first_timer_high_byte, first_timer_low_byte} + 17'h00001;
  assign t0_low_sum  = {1'b0, first_timer_low_byte} + 9'h001;
  assign t0_high_sum = {1'b0, first_timer_high_byte} + 9'h001;
  assign t1_sum13 = {1'b0, th1, tl1[4:0]} + 14'h0001;
  assign t1_sum16 = {1'b0, th1, tl1} + 17'h00001;
  assign tl1_sum  = {1'b0, tl1} + 9'h001;

  always_comb begin
    next_first_timer_low_byte  = first_timer_low_byte;
    next_first_timer_high_byte = first_timer_high_byte;
    t0_ovf                     = 1'b0;
    t0_high_ovf                = 1'b0;
    if (t0_tick) begin
      unique case (t0_mode)
        MODE_13BIT: begin
          {t0_ovf, next_first_timer_high_byte} = t0_sum13[13:5];
          next_first_timer_low_byte = {first_timer_low_byte[7:5], t0_sum13[4:0]};
        end
        MODE_16BIT: begin
          {t0_ovf, next_first_timer_high_byte, next_first_timer_low_byte} = t0_sum16;
        end
        MODE_8BIT_RELOAD: begin
          t0_ovf                    = t0_low_sum[8];
          next_first_timer_low_byte = t0_low_sum[8] ? first_timer_high_byte : t0_low_sum[7:0];
        end
        MODE_SPLIT: begin
          {t0_ovf, next_first_timer_low_byte} = t0_low_sum;
        end
      endcase
    end
    if (t0_high_tick) begin
      {t0_high_ovf, next_first_timer_high_byte} = t0_high_sum;
    end
  end

  always_comb begin
    next_tl1 = tl1;
    next_th1 = th1;
    t1_ovf   = 1'b0;
    if (t1_tick) begin
      unique case (t1_mode)
        MODE_13BIT: begin
          {t1_ovf, next_th1} = t1_sum13[13:5];
          next_tl1 = {tl1[7:5], t1_sum13[4:0]};
        end
        MODE_16BIT: begin
          {t1_ovf, next_th1, next_tl1} = t1_sum16;
        end
        MODE_8BIT_RELOAD: begin
          t1_ovf   = tl1_sum[8];
          next_tl1 = tl1_sum[8] ? th1 : tl1_sum[7:0];
        end
        MODE_SPLIT: begin
          t1_ovf = 1'b0;
        end
      endcase
    end
  end

  // Software writes take precedence over counting
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      first_timer_low_byte  <= RESET_BYTE;
      first_timer_high_byte <= RESET_BYTE;
      tl1 <= RESET_BYTE;
      th1 <= RESET_BYTE;
    end else begin
      first_timer_low_byte  <= (wr_en && addr == ADDR_T0_LOW) ? wr_data : next_first_timer_low_byte;
      first_timer_high_byte <= (wr_en && addr == ADDR_T0_HIGH) ? wr_data : next_first_timer_high_byte;
      tl1 <= (wr_en && addr == ADDR_T1_LOW) ? wr_data : next_tl1;
      th1 <= (wr_en && addr == ADDR_T1_HIGH) ? wr_data : next_th1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flags and pulse
  logic t1_flag_set;
  assign t1_flag_set = split ? t0_high_ovf : t1_ovf;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      second_timer_overflow_flag <= 1'b0;
    else if (t1_flag_set)
      second_timer_overflow_flag <= 1'b1;
    else if (vector_t1)
      second_timer_overflow_flag <= 1'b0;
    else if (wr_control)
      second_timer_overflow_flag <= wr_data[BIT_T1_FLAG];
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      first_timer_overflow_flag <= 1'b0;
    else if (t0_ovf)
      first_timer_overflow_flag <= 1'b1;
    else if (vector_t0)
      first_timer_overflow_flag <= 1'b0;
    else if (wr_control)
      first_timer_overflow_flag <= wr_data[BIT_T0_FLAG];
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      second_timer_overflow_pulse <= 1'b0;
    else
      second_timer_overflow_pulse <= t1_ovf;
  end

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt flags
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      ext_irq1_flag <= 1'b0;
    else if (!ext_irq1_type_select)
      ext_irq1_flag <= irq1_active;
    else if (irq1_edge)
      ext_irq1_flag <= 1'b1;
    else if (vector_irq1)
      ext_irq1_flag <= 1'b0;
    else if (wr_control)
      ext_irq1_flag <= wr_data[BIT_IRQ1_FLAG];
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      ext_irq0_flag <= 1'b0;
    else if (!ext_irq0_type_select)
      ext_irq0_flag <= irq0_active;
    else if (irq0_edge)
      ext_irq0_flag <= 1'b1;
    else if (vector_irq0)
      ext_irq0_flag <= 1'b0;
    else if (wr_control)
      ext_irq0_flag <= wr_data[BIT_IRQ0_FLAG];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  logic [7:0] control_value;

  always_comb begin
    control_value            = RESET_BYTE;
    control_value[BIT_T1_FLAG]   = second_timer_overflow_flag;
    control_value[BIT_T1_RUN]    = second_timer_run;
    control_value[BIT_T0_FLAG]   = first_timer_overflow_flag;
    control_value[BIT_T0_RUN]    = first_timer_run;
    control_value[BIT_IRQ1_FLAG] = ext_irq1_flag;
    control_value[BIT_IRQ1_TYPE] = ext_irq1_type_select;
    control_value[BIT_IRQ0_FLAG] = ext_irq0_flag;
    control_value[BIT_IRQ0_TYPE] = ext_irq0_type_select;
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      rd_data <= RESET_BYTE;
    else if (rd_en) begin
      unique case (addr)
        ADDR_CONTROL: rd_data <= control_value;
        ADDR_MODE:    rd_data <= timer_mode_register;
        ADDR_T0_LOW:  rd_data <= first_timer_low_byte;
        ADDR_T0_HIGH: rd_data <= first_timer_high_byte;
        ADDR_T1_LOW:  rd_data <= tl1;
        ADDR_T1_HIGH: rd_data <= th1;
        ADDR_CLOCK:   rd_data <= clock_select;
        ADDR_IRQ_CFG: rd_data <= ext_irq_config_register;
      endcase
    end else
      rd_data <= RESET_BYTE;
  end

endmodule // timer_split_mode_control

// File: common/timer_split_pkg.sv
// How it works
// - Split mode: two independent 8-bit counters
// - Low byte uses first run/source/gate/flag
// - Low byte counts clock or event falls
// - High byte is timer only, clock/prescaled
// - High byte runs while second run set
// - High byte overflow sets second flag
// - Split: second timer no events, no flag
// - Split: second overflow pulse still delivered
// - Split: second timer stops in mode three
// - Bit 7 second flag, vector clears
// - Bit 6 second timer run control
// - Bit 5 first flag, vector clears
// - Bit 4 first timer run control
// - Bit 3 irq1 flag, edge latched/level
// - Bit 2 selects irq1 edge or level
// - Bit 1 irq0 flag, set by type
// - Irq1 polarity from configuration register
// - Irq1 type: zero level, one edge
package timer_split_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register byte addresses
  localparam logic [2:0] ADDR_CONTROL  = 3'h0;
  localparam logic [2:0] ADDR_MODE     = 3'h1;
  localparam logic [2:0] ADDR_T0_LOW   = 3'h2;
  localparam logic [2:0] ADDR_T0_HIGH  = 3'h3;
  localparam logic [2:0] ADDR_T1_LOW   = 3'h4;
  localparam logic [2:0] ADDR_T1_HIGH  = 3'h5;
  localparam logic [2:0] ADDR_CLOCK    = 3'h6;
  localparam logic [2:0] ADDR_IRQ_CFG  = 3'h7;

  // Control register fields
  localparam int BIT_T1_FLAG   = 7;
  localparam int BIT_T1_RUN    = 6;
  localparam int BIT_T0_FLAG   = 5;
  localparam int BIT_T0_RUN    = 4;
  localparam int BIT_IRQ1_FLAG = 3;
  localparam int BIT_IRQ1_TYPE = 2;
  localparam int BIT_IRQ0_FLAG = 1;
  localparam int BIT_IRQ0_TYPE = 0;

  // Mode register fields
  localparam int MODE0_LSB   = 0;
  localparam int BIT_CT0     = 2;
  localparam int BIT_T0_GATE = 3;
  localparam int MODE1_LSB   = 4;
  localparam int BIT_CT1     = 6;
  localparam int BIT_T1_GATE = 7;

  // Clock select register fields
  localparam int SCALE_LSB = 0;
  localparam int BIT_T0M   = 3;
  localparam int BIT_T1M   = 4;

  // Interrupt configuration fields
  localparam int BIT_IRQ0_POL = 3;
  localparam int BIT_IRQ1_POL = 7;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Prescaler divisors
  localparam int PRESC_W = 6;
  localparam logic [5:0] DIV_12 = 6'h0C;
  localparam logic [5:0] DIV_4  = 6'h04;
  localparam logic [5:0] DIV_48 = 6'h30;
  localparam logic [5:0] DIV_8  = 6'h08;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8BIT_RELOAD,
    MODE_SPLIT
  } timer_mode_type;

endpackage

// File: src/pin_sync_edge.sv
`timescale 1ns/1ps
module pin_sync_edge (
  input  wire logic mclk,
  input  wire logic rst_sync_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta;
  logic prev;

  // Two-stage synchroniser, then history for edges
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta  <= 1'b1;
      level <= 1'b1;
      prev  <= 1'b1;
    end else begin
      meta  <= pin;
      level <= meta;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule // pin_sync_edge

// File: bench/timer_split_chk.sv
`timescale 1ns/1ps
module timer_split_chk
  import timer_split_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic              vector_t0,
  input wire logic              vector_t1,
  input wire logic              first_timer_overflow_flag,
  input wire logic              second_timer_overflow_flag,
  input wire logic              ext_irq0_flag,
  input wire logic              ext_irq1_flag,
  input wire logic              second_timer_overflow_pulse
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_T1_FLAG_CLEAR:
    assert property ($fell(second_timer_overflow_flag) |-> $past(vector_t1)
      || $past(wr_en && addr == ADDR_CONTROL && !wr_data[BIT_T1_FLAG]))
      else $error("second flag fell without cause");
  AST_T0_FLAG_CLEAR:
    assert property ($fell(first_timer_overflow_flag) |-> $past(vector_t0)
      || $past(wr_en && addr == ADDR_CONTROL && !wr_data[BIT_T0_FLAG]))
      else $error("first flag fell without cause");
  AST_PULSE_ONE:
    assert property (second_timer_overflow_pulse |=> !second_timer_overflow_pulse) else $error("pulse too long");
  AST_RUN_READBACK:
    assert property (wr_en && addr == ADDR_CONTROL ##1 !wr_en ##1 rd_en && addr == ADDR_CONTROL |=>
      rd_data[BIT_T1_RUN] == $past(wr_data[BIT_T1_RUN], 3) &&
      rd_data[BIT_T0_RUN] == $past(wr_data[BIT_T0_RUN], 3))
      else $error("run bits wrong");
  AST_TYPE_READBACK:
    assert property (wr_en && addr == ADDR_CONTROL ##1 !wr_en ##1 rd_en && addr == ADDR_CONTROL |=>
      rd_data[BIT_IRQ1_TYPE] == $past(wr_data[BIT_IRQ1_TYPE], 3) &&
      rd_data[BIT_IRQ0_TYPE] == $past(wr_data[BIT_IRQ0_TYPE], 3))
      else $error("type bits wrong");
  AST_FLAG_READ:
    assert property (rd_en && addr == ADDR_CONTROL |=> {rd_data[7], rd_data[5], rd_data[3], rd_data[1]} ==
      $past({second_timer_overflow_flag, first_timer_overflow_flag, ext_irq1_flag, ext_irq0_flag}))
      else $error("flag bits differ from outputs");
  AST_CFG_RSVD:
    assert property (rd_en && addr == ADDR_IRQ_CFG |=> (rd_data & 8'h77) == 8'h00) else $error("config spare bits");
  AST_RD_IDLE:
    assert property (!$past(rd_en) |-> rd_data == 8'h00) else $error("read data outside read cycle");
endmodule // timer_split_chk

// File: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import timer_split_pkg::*;
  logic              mclk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic              wr_en;
  logic              rd_en;
  logic              t0_pin;
  logic              t1_pin;
  logic              irq0_in;
  logic              irq1_in;
  logic              vec_t0;
  logic              vec_t1;
  logic              vec_i0;
  logic              vec_i1;
  logic              flag_t0;
  logic              flag_t1;
  logic              flag_i0;
  logic              flag_i1;
  logic              pulse;
  int                error_cnt;
  int                n_tests;

  timer_split_mode_control dut_u (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .t0_event_pin(t0_pin), .t1_event_pin(t1_pin), .ext_irq0_input(irq0_in),
    .ext_irq1_input(irq1_in), .vector_t0(vec_t0), .vector_t1(vec_t1), .vector_irq0(vec_i0),
    .vector_irq1(vec_i1), .first_timer_overflow_flag(flag_t0), .second_timer_overflow_flag(flag_t1),
    .ext_irq0_flag(flag_i0), .ext_irq1_flag(flag_i1), .second_timer_overflow_pulse(pulse)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
    @(posedge mclk);
  endtask
  // Order of flags: second timer, first timer, irq1, irq0
  task automatic flags(input logic [3:0] exp);
    @(negedge mclk);
    chk({4'h0, flag_t1, flag_t0, flag_i1, flag_i0}, {4'h0, exp});
    @(posedge mclk);
  endtask
  task automatic wait_pulse(input logic exp_tf1);
    for (int i = 0; i < 300 && pulse !== 1'b1; i++) @(negedge mclk);
    chk({6'h00, pulse, flag_t1}, {6'h00, 1'b1, exp_tf1});
    @(posedge mclk);
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, wr_en, rd_en, vec_t0, vec_t1, vec_i0, vec_i1} = '0;
    addr = '0;
    wr_data = '0;
    {t0_pin, t1_pin, irq0_in, irq1_in} = 4'hF;
    error_cnt = 0;
    n_tests = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(5);
    for (int a = 0; a < 8; a++) rd(a[2:0], RESET_BYTE);
    wr(ADDR_CONTROL, 8'h55);
    rd(ADDR_CONTROL, 8'h55);
    wr(ADDR_CONTROL, 8'h00);
    done("reset_and_control");
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_CLOCK, 8'h08);
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_T0_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h40);
    cyc(8);
    flags(4'h8);
    rd(ADDR_T0_LOW, 8'h00);
    vec_t1 <= 1'b1;
    @(posedge mclk);
    vec_t1 <= 1'b0;
    flags(4'h0);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_T0_HIGH, 8'h20);
    cyc(20);
    rd(ADDR_T0_HIGH, 8'h20);
    done("split_high_byte");
    wr(ADDR_T0_LOW, 8'hFE);
    wr(ADDR_CONTROL, 8'h10);
    cyc(6);
    flags(4'h4);
    vec_t0 <= 1'b1;
    @(posedge mclk);
    vec_t0 <= 1'b0;
    flags(4'h0);
    wr(ADDR_T0_LOW, 8'hFE);
    cyc(6);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h0B);
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    cyc(10);
    rd(ADDR_T0_LOW, 8'h00);
    wr(ADDR_MODE, 8'h07);
    wr(ADDR_T0_LOW, 8'h00);
    repeat (3) begin
      t0_pin <= 1'b0;
      cyc(4);
      t0_pin <= 1'b1;
      cyc(4);
    end
    rd(ADDR_T0_LOW, 8'h03);
    wr(ADDR_CONTROL, 8'h00);
    done("split_low_byte");
    wr(ADDR_CLOCK, 8'h18);
    wr(ADDR_T1_HIGH, 8'hF0);
    wr(ADDR_T1_LOW, 8'hF0);
    wr(ADDR_MODE, 8'h63);
    wait_pulse(1'b0);
    wr(ADDR_MODE, 8'h73);
    wr(ADDR_T1_LOW, 8'h05);
    cyc(10);
    rd(ADDR_T1_LOW, 8'h05);
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_CONTROL, 8'h40);
    wait_pulse(1'b1);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MODE, 8'h60);
    wr(ADDR_T1_LOW, 8'h10);
    wr(ADDR_CONTROL, 8'h40);
    repeat (2) begin
      t1_pin <= 1'b0;
      cyc(4);
      t1_pin <= 1'b1;
      cyc(4);
    end
    rd(ADDR_T1_LOW, 8'h12);
    wr(ADDR_CONTROL, 8'h00);
    done("second_timer");
    wr(ADDR_IRQ_CFG, 8'hFF);
    rd(ADDR_IRQ_CFG, 8'h88);
    cyc(4);
    flags(4'h3);
    irq0_in <= 1'b0;
    irq1_in <= 1'b0;
    cyc(6);
    flags(4'h0);
    wr(ADDR_CONTROL, 8'h05);
    {irq0_in, irq1_in} <= 2'b11;
    cyc(4);
    {irq0_in, irq1_in} <= 2'b00;
    cyc(6);
    flags(4'h3);
    {vec_i0, vec_i1} <= 2'b11;
    @(posedge mclk);
    {vec_i0, vec_i1} <= 2'b00;
    flags(4'h0);
    wr(ADDR_IRQ_CFG, 8'h00);
    cyc(6);
    wr(ADDR_CONTROL, 8'h05);
    {irq0_in, irq1_in} <= 2'b11;
    cyc(6);
    {irq0_in, irq1_in} <= 2'b00;
    cyc(6);
    rd(ADDR_CONTROL, 8'h0F);
    wr(ADDR_CONTROL, 8'h05);
    rd(ADDR_CONTROL, 8'h05);
    done("external_irq");
    tally_and_finish();
  end

  initial begin
    repeat (6000) @(posedge mclk);
    error_cnt++;
    $display("unexpected at %0t: run did not finish", $time);
    tally_and_finish();
  end
endmodule // tb_top

bind timer_split_mode_control timer_split_chk chk_u (
  .mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .rd_data(rd_data), .vector_t0(vector_t0), .vector_t1(vector_t1),
  .first_timer_overflow_flag(first_timer_overflow_flag), .second_timer_overflow_flag(second_timer_overflow_flag),
  .ext_irq0_flag(ext_irq0_flag), .ext_irq1_flag(ext_irq1_flag),
  .second_timer_overflow_pulse(second_timer_overflow_pulse)
);
